// [include/lane_map_params.svh]
/*
  Register offsets, field positions, reset values and timing counts for the
  output pattern and lane map block.
  Assumes 8-bit register addresses and 16-bit register data.
*/
`ifndef LANE_MAP_PARAMS_SVH
`define LANE_MAP_PARAMS_SVH

`define REG_ANALOG_INPUT_SWAP     8'h24
`define REG_OUTPUT_PATTERN_SELECT 8'h25
`define REG_PATTERN_CODE_FIRST    8'h26
`define REG_PATTERN_CODE_SECOND   8'h27
`define REG_FINE_GAIN_ENABLE      8'h30
`define REG_FINE_GAIN_BASE        8'h34
`define REG_CHANNEL_MODE          8'h31

`define DUAL_SWAP_LSB             4
`define SINGLE_SWAP_BIT           6
`define PATTERN_FIELD_LSB         4
`define PATTERN_CODE_LSB          8
`define FINE_GAIN_ENABLE_BIT      0
`define CHANNEL_MODE_SINGLE_BIT   0

`define PATTERN_FIELD_RESET       3'h7
`define PATTERN_CODE_RESET        8'h00
`define FINE_GAIN_RESET           7'h00

`define CLOCK_PERIOD_NS           20
`define BIT_CLOCK_DIVIDE          2

`endif

// [include/lane_map_pkg.sv]
/*
  Types shared by the output pattern and lane map block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lane_map_pkg;
  typedef enum logic [1:0] {
    output_normal_type_val = 2'b00,
    output_ramp_type_val   = 2'b01,
    output_toggle_type_val = 2'b10,
    output_hold_type_val   = 2'b11
  } output_mode_type;
endpackage

// [core/fine_gain_store.sv]
/*
  Eight fine gain words, one per converter branch, with registered read out.
  Assumes a single clock and writes from the register port of the parent.
*/
`timescale 1ns/1ns
`default_nettype none
module fine_gain_store #(
  parameter int branches = 8,
  parameter int width    = 7
) (
  input  wire logic                        clock,
  input  wire logic                        rstn,
  input  wire logic                        write_enable,
  input  wire logic [2:0]                  write_index,
  input  wire logic [width-1:0]            write_data,
  output var  logic [branches*width-1:0]   gains
);
  initial begin
    if (branches != 8) $error("fine_gain_store needs eight branches");
  end

  logic [width-1:0] store [branches];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < branches; i++) store[i] <= '0;
      gains <= '0;
    end else begin
      if (write_enable) store[write_index] <= write_data;
      for (int i = 0; i < branches; i++) gains[i*width +: width] <= store[i];
    end
  end
endmodule // fine_gain_store
`default_nettype wire

// [core/lane_map_core.sv]
/*
  Output side control of an interleaved 8-bit converter: input polarity swap,
  ramp and toggle test patterns, lane mapping, per-branch fine gain.
  Assumes branch samples arrive synchronous to clock, and a simple register
  write/read port on the same clock drives the configuration.
*/
`timescale 1ns/1ns
`default_nettype none
`include "lane_map_params.svh"

// Notes on behaviour
// - Dual mode: two bits swap each channel
// - Single mode: one bit swaps input
// - Swap set makes negative pin positive
// - Pattern replaces converted data on lanes
// - Ramp D6, toggle D5 selects
// - Ramp counts up, wraps at full scale
// - Toggle alternates first and second code
// - First code D15:D8, resets zero
// - Second code D15:D8, resets zero
// - Pattern field resets to 111b
// - Offset binary code, zero to 255
// - Dual mode lane and branch map
// - Single mode lane and branch map
// - Each branch has own fine gain
// - Frame and bit clocks from generator
// - Sample strobes divided from one clock
// - Fine gain only when enabled
module lane_map_core #(
  parameter int sample_width = 8,
  parameter int gain_width   = 7
) (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  input  wire logic [7:0]                reg_address,
  input  wire logic [15:0]               reg_write_data,
  output var  logic [15:0]               reg_read_data,
  input  wire logic [8*sample_width-1:0] branch_samples,
  input  wire logic [7:0]                branch_input_positive,
  output var  logic [7:0]                branch_input_swapped,
  output var  logic [sample_width-1:0]   lane_one_a,
  output var  logic [sample_width-1:0]   lane_one_b,
  output var  logic [sample_width-1:0]   lane_two_a,
  output var  logic [sample_width-1:0]   lane_two_b,
  output var  logic [sample_width-1:0]   lane_three_a,
  output var  logic [sample_width-1:0]   lane_three_b,
  output var  logic [sample_width-1:0]   lane_four_a,
  output var  logic [sample_width-1:0]   lane_four_b,
  output var  logic                      frame_clock_out,
  output var  logic                      bit_clock_out,
  output var  logic [7:0]                sample_strobe
);
  initial begin
    if (sample_width != 8) $error("lane_map_core serves 8-bit samples only");
    if (gain_width != 7) $error("lane_map_core serves 7-bit fine gain only");
  end

  typedef struct packed {
    logic [1:0]              dual_input_swap;
    logic                    single_input_swap;
    logic [2:0]              pattern_field;
    logic [7:0]              pattern_code_a;
    logic [7:0]              pattern_code_b;
    logic                    fine_gain_enable;
    logic                    single_mode;
    logic [sample_width-1:0] ramp;
    logic                    toggle_phase;
    logic [1:0]              bit_divider;
    logic [2:0]              sample_phase;
    logic                    frame_clock_out;
    logic                    bit_clock_out;
    logic [7:0]              sample_strobe;
    logic [7:0]              branch_input_swapped;
    logic [8*sample_width-1:0] lanes;
    logic [15:0]             reg_read_data;
  } state_type;

  state_type state;
  state_type next_state;

  logic [8*gain_width-1:0] gains;
  logic                    gain_write;

  // Four word addresses share one decode; the low address bits pick the branch pair
  assign gain_write = reg_write && reg_address[7:2] == 6'(`REG_FINE_GAIN_BASE >> 2);

  fine_gain_store #(
    .branches (8),
    .width    (gain_width)
  ) gain_store (
    .clock        (clock),
    .rstn         (rstn),
    .write_enable (gain_write),
    .write_index  ({reg_address[1:0], reg_write_data[8]}),
    .write_data   (reg_write_data[gain_width-1:0]),
    .gains        (gains)
  );

  // Fine gain: 1 + g * 2^-13 with g signed, result saturated to the code range
  function automatic logic [sample_width-1:0] apply_gain(
    input logic [sample_width-1:0] sample,
    input logic [gain_width-1:0]   gain,
    input logic                    enable
  );
    logic signed [23:0] scaled;
    logic signed [24:0] total;
    scaled = $signed({1'b0, sample, 13'h0000}) + $signed({1'b0, sample}) * $signed(gain);
    total  = {scaled[23], scaled} + 25'sh0001000;
    if (!enable) return sample;
    if (total[24]) return '0;
    if (total[23:13] > 11'h0FF) return '1;
    return total[20:13];
  endfunction

  // Branch number (zero based) feeding each lane slot, slots ordered 1A..4B
  function automatic logic [2:0] branch_of(input logic [2:0] slot, input logic single);
    logic [23:0] dual_map;
    logic [23:0] single_map;
    dual_map   = {3'd7, 3'd5, 3'd6, 3'd4, 3'd3, 3'd1, 3'd2, 3'd0};
    single_map = {3'd3, 3'd6, 3'd2, 3'd7, 3'd4, 3'd1, 3'd5, 3'd0};
    return single ? single_map[slot*3 +: 3] : dual_map[slot*3 +: 3];
  endfunction

  lane_map_pkg::output_mode_type mode;

  always_comb begin
    case (state.pattern_field)
      3'b100, 3'b110, 3'b101: mode = lane_map_pkg::output_ramp_type_val;
      3'b010:                 mode = lane_map_pkg::output_toggle_type_val;
      3'b111:                 mode = lane_map_pkg::output_normal_type_val;
      default:                mode = lane_map_pkg::output_hold_type_val;
    endcase
  end

  always_comb begin
    logic [2:0] branch;
    logic [sample_width-1:0] pattern;
    branch = '0;
    pattern = '0;
    next_state = state;

    if (reg_write) begin
      case (reg_address)
        `REG_ANALOG_INPUT_SWAP: begin
          next_state.dual_input_swap   = reg_write_data[`DUAL_SWAP_LSB +: 2];
          next_state.single_input_swap = reg_write_data[`SINGLE_SWAP_BIT];
        end
        `REG_OUTPUT_PATTERN_SELECT:
          next_state.pattern_field = reg_write_data[`PATTERN_FIELD_LSB +: 3];
        `REG_PATTERN_CODE_FIRST:
          next_state.pattern_code_a = reg_write_data[`PATTERN_CODE_LSB +: 8];
        `REG_PATTERN_CODE_SECOND:
          next_state.pattern_code_b = reg_write_data[`PATTERN_CODE_LSB +: 8];
        `REG_FINE_GAIN_ENABLE:
          next_state.fine_gain_enable = reg_write_data[`FINE_GAIN_ENABLE_BIT];
        `REG_CHANNEL_MODE:
          next_state.single_mode = reg_write_data[`CHANNEL_MODE_SINGLE_BIT];
        default: begin
        end
      endcase
    end

    next_state.reg_read_data = '0;
    if (reg_read) begin
      case (reg_address)
        `REG_ANALOG_INPUT_SWAP:
          next_state.reg_read_data = {9'h000, state.single_input_swap, state.dual_input_swap, 4'h0};
        `REG_OUTPUT_PATTERN_SELECT:
          next_state.reg_read_data = {9'h000, state.pattern_field, 4'h0};
        `REG_PATTERN_CODE_FIRST:   next_state.reg_read_data = {state.pattern_code_a, 8'h00};
        `REG_PATTERN_CODE_SECOND:  next_state.reg_read_data = {state.pattern_code_b, 8'h00};
        `REG_FINE_GAIN_ENABLE:     next_state.reg_read_data = {15'h0000, state.fine_gain_enable};
        `REG_CHANNEL_MODE:         next_state.reg_read_data = {15'h0000, state.single_mode};
        default:                   next_state.reg_read_data = 16'h0000;
      endcase
    end

    // Polarity per branch: channel 1 owns branches 1-4, channel 2 branches 5-8
    for (int b = 0; b < 8; b++) begin
      if (state.single_mode)
        next_state.branch_input_swapped[b] = branch_input_positive[b] ^ state.single_input_swap;
      else
        next_state.branch_input_swapped[b] = branch_input_positive[b] ^ state.dual_input_swap[b/4];
    end

    // Patterns step once per output word so every lane sees the same sequence
    next_state.ramp = (mode == lane_map_pkg::output_ramp_type_val) ?
                      state.ramp + 1'b1 : '0;
    next_state.toggle_phase = (mode == lane_map_pkg::output_toggle_type_val) ?
                              ~state.toggle_phase : 1'b0;

    case (mode)
      lane_map_pkg::output_ramp_type_val:   pattern = state.ramp;
      lane_map_pkg::output_toggle_type_val: pattern = state.toggle_phase ? state.pattern_code_b
                                                                         : state.pattern_code_a;
      lane_map_pkg::output_hold_type_val:   pattern = state.pattern_code_a;
      default:                              pattern = '0;
    endcase

    for (int s = 0; s < 8; s++) begin
      branch = branch_of(3'(s), state.single_mode);
      if (mode != lane_map_pkg::output_normal_type_val)
        next_state.lanes[s*sample_width +: sample_width] = pattern;
      else
        next_state.lanes[s*sample_width +: sample_width] =
          apply_gain(branch_samples[branch*sample_width +: sample_width],
                     gains[branch*gain_width +: gain_width], state.fine_gain_enable);
    end

    // Link clocks and sample strobes all divided from the one input clock
    next_state.bit_divider = state.bit_divider + 1'b1;
    if (state.bit_divider == 2'(`BIT_CLOCK_DIVIDE - 1)) begin
      next_state.bit_divider = '0;
      next_state.bit_clock_out = ~state.bit_clock_out;
    end
    next_state.sample_phase = state.sample_phase + 1'b1;
    next_state.frame_clock_out = state.sample_phase[2];
    for (int b = 0; b < 8; b++) begin
      if (state.single_mode)
        next_state.sample_strobe[b] = state.sample_phase == 3'(b);
      else
        next_state.sample_strobe[b] = state.sample_phase[1:0] == 2'(b % 4);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
      state.pattern_field <= `PATTERN_FIELD_RESET;
      state.pattern_code_a <= `PATTERN_CODE_RESET;
      state.pattern_code_b <= `PATTERN_CODE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign reg_read_data        = state.reg_read_data;
  assign branch_input_swapped = state.branch_input_swapped;
  assign lane_one_a   = state.lanes[0*sample_width +: sample_width];
  assign lane_one_b   = state.lanes[1*sample_width +: sample_width];
  assign lane_two_a   = state.lanes[2*sample_width +: sample_width];
  assign lane_two_b   = state.lanes[3*sample_width +: sample_width];
  assign lane_three_a = state.lanes[4*sample_width +: sample_width];
  assign lane_three_b = state.lanes[5*sample_width +: sample_width];
  assign lane_four_a  = state.lanes[6*sample_width +: sample_width];
  assign lane_four_b  = state.lanes[7*sample_width +: sample_width];
  assign frame_clock_out = state.frame_clock_out;
  assign bit_clock_out   = state.bit_clock_out;
  assign sample_strobe   = state.sample_strobe;
endmodule // lane_map_core
`default_nettype wire

// [dv/lane_map_asserts.sv]
/* Port checker for lane_map_core, bound to every instance.
   Assumes register writes land on the edge that takes them. */
`timescale 1ns/1ns
`default_nettype none
module lane_map_asserts (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_address,
  input wire logic [15:0] reg_write_data,
  input wire logic [15:0] reg_read_data,
  input wire logic [63:0] branch_samples,
  input wire logic [7:0]  branch_input_positive,
  input wire logic [7:0]  branch_input_swapped,
  input wire logic [7:0]  lane_one_a,
  input wire logic [7:0]  lane_one_b,
  input wire logic [7:0]  lane_two_a,
  input wire logic [7:0]  lane_two_b,
  input wire logic [7:0]  lane_three_a,
  input wire logic [7:0]  lane_three_b,
  input wire logic [7:0]  lane_four_a,
  input wire logic [7:0]  lane_four_b,
  input wire logic        frame_clock_out,
  input wire logic        bit_clock_out,
  input wire logic [7:0]  sample_strobe
);
  logic [15:0] mir [0:63];
  logic [63:0] prev;
  logic [2:0]  quiet;
  logic [2:0]  same;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Own copy of the settings, so no property leans on hidden registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      foreach (mir[i]) mir[i] <= (i == 37) ? 16'h0070 : 16'h0000;
      prev <= '0;
      quiet <= '0;
      same <= '0;
    end else begin
      if (reg_write && reg_address < 8'h40) mir[reg_address[5:0]] <= reg_write_data;
      prev <= branch_samples;
      quiet <= reg_write ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
      same <= (branch_samples != prev) ? 3'h0 : same + {2'h0, same != 3'h7};
    end
  end
  wire logic [2:0]  fld  = mir[6'h25][6:4];
  wire logic        sgl  = mir[6'h31][0];
  wire logic        gen  = mir[6'h30][0];
  wire logic        ok   = quiet == 3'h7;
  wire logic        ramp = fld[2] && fld != 3'h7;
  wire logic [7:0]  ca   = mir[6'h26][15:8];
  wire logic [7:0]  cb   = mir[6'h27][15:8];
  wire logic [7:0]  sw   = mir[6'h24][7:0];
  wire logic [7:0]  mask = sgl ? {8{sw[6]}} : {{4{sw[5]}}, {4{sw[4]}}};
  wire logic [63:0] b    = branch_samples;
  wire logic [63:0] lanes = {lane_four_b, lane_four_a, lane_three_b, lane_three_a,
                             lane_two_b, lane_two_a, lane_one_b, lane_one_a};
  wire logic [63:0] dmap = {b[63:56], b[47:40], b[55:48], b[39:32], b[31:24], b[15:8], b[23:16], b[7:0]};
  wire logic [63:0] smap = {b[31:24], b[55:48], b[23:16], b[63:56], b[39:32], b[15:8], b[47:40], b[7:0]};
  property p_swap; ok |-> branch_input_swapped == $past(branch_input_positive ^ mask); endproperty
  a_swap: assert property (p_swap) else $error("input swap wrong");
  property p_ramp; ok && ramp |-> lane_one_a == 8'($past(lane_one_a) + 8'h01); endproperty
  a_ramp: assert property (p_ramp) else $error("ramp step wrong");
  property p_start; reg_write && reg_address == 8'h25 && reg_write_data[6] && reg_write_data[6:4] != 3'h7
    && !ramp |-> ##[2:3] lane_one_a == 8'h00; endproperty
  a_start: assert property (p_start) else $error("ramp did not start at zero");
  property p_same; ok && fld != 3'h7 |-> lanes == {8{lane_one_a}}; endproperty
  a_same: assert property (p_same) else $error("lanes differ in pattern mode");
  property p_toggle; ok && fld == 3'h2 |-> lane_one_a == (($past(lane_one_a) == ca) ? cb : ca); endproperty
  a_toggle: assert property (p_toggle) else $error("toggle order wrong");
  property p_hold; ok && !fld[2] && fld != 3'h2 |-> lane_one_a == ca; endproperty
  a_hold: assert property (p_hold) else $error("single code wrong");
  property p_map; ok && fld == 3'h7 && !gen && same == 3'h7 |-> lanes == (sgl ? smap : dmap); endproperty
  a_map: assert property (p_map) else $error("lane map wrong");
  property p_rdfield; $past(reg_read && reg_address == 8'h25) |-> reg_read_data[6:4] == $past(fld); endproperty
  a_rdfield: assert property (p_rdfield) else $error("pattern field readback wrong");
  property p_rdcode; $past(reg_read && reg_address == 8'h27) |-> reg_read_data[15:8] == $past(cb); endproperty
  a_rdcode: assert property (p_rdcode) else $error("second code readback wrong");
  property p_bit; $rose(bit_clock_out) |=> bit_clock_out ##1 !bit_clock_out; endproperty
  a_bit: assert property (p_bit) else $error("bit clock period wrong");
  property p_frame; $rose(frame_clock_out) |-> ##8 $rose(frame_clock_out); endproperty
  a_frame: assert property (p_frame) else $error("frame clock period wrong");
  property p_strobe; ok |-> (sgl ? $onehot(sample_strobe)
    : (sample_strobe[7:4] == sample_strobe[3:0] && $onehot(sample_strobe[3:0]))); endproperty
  a_strobe: assert property (p_strobe) else $error("sample strobes wrong");
  c_wrap: cover property (ramp && lane_one_a == 8'hFF ##1 lane_one_a == 8'h00);
  c_toggle: cover property (ok && fld == 3'h2);
  c_single: cover property (ok && sgl && fld == 3'h7 && same == 3'h7);
endmodule // lane_map_asserts
bind lane_map_core lane_map_asserts lane_map_asserts_i (.*);
`default_nettype wire

// [dv/lane_receiver.sv]
/* Far-side receiver model: aligns on the frame clock, measures the link clocks.
   Assumes it watches lane 1A of lane_map_core on the core clock. */
`timescale 1ns/1ns
`default_nettype none
module lane_receiver (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       frame_clock_out,
  input  wire logic       bit_clock_out,
  input  wire logic [7:0] lane_one_a,
  output var  logic [7:0] word,
  output var  int         frame_len,
  output var  int         bit_edges
);
  int   cnt;
  int   edges;
  logic fprev;
  logic bprev;
  wire logic rise = frame_clock_out && !fprev;
  wire logic flip = bit_clock_out != bprev;
  // Word boundaries are known only from the frame rise, as in real alignment logic
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {cnt, edges, fprev, bprev, word, frame_len, bit_edges} <= '0;
    end else begin
      fprev <= frame_clock_out;
      bprev <= bit_clock_out;
      cnt <= rise ? 1 : cnt + 1;
      edges <= rise ? 0 : edges + int'(flip);
      if (rise) begin
        word <= lane_one_a;
        frame_len <= cnt;
        bit_edges <= edges + int'(flip);
      end
    end
  end
endmodule // lane_receiver
`default_nettype wire

// [dv/test_adc_output_pattern_and_lane_map.sv]
/* Self-checking bench for lane_map_core with a lane receiver.
   Assumes package, design, checker and receiver are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module test_adc_output_pattern_and_lane_map;
  logic        clock, rstn, reg_write, reg_read, frame_clock_out, bit_clock_out;
  logic [7:0]  reg_address, branch_input_positive, branch_input_swapped, sample_strobe;
  logic [15:0] reg_write_data, reg_read_data, rd;
  logic [63:0] branch_samples;
  logic [7:0]  lane_one_a, lane_one_b, lane_two_a, lane_two_b;
  logic [7:0]  lane_three_a, lane_three_b, lane_four_a, lane_four_b, word, ca, cb, v;
  int          frame_len, bit_edges, mismatches, num_checks;
  wire logic [63:0] lanes = {lane_four_b, lane_four_a, lane_three_b, lane_three_a,
                             lane_two_b, lane_two_a, lane_one_b, lane_one_a};
  lane_map_core lane_map_core_i (.*);
  lane_receiver lane_receiver_i (.*);
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_lanes(input string what, input logic [63:0] exp);
    for (int i = 0; i < 8; i++) check(what, {8'h00, exp[8*i+:8]}, {8'h00, lanes[8*i+:8]});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_write = 1'b1;
    reg_address = a;
    reg_write_data = d;
    tick(1);
    reg_write = 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    reg_read = 1'b1;
    reg_address = a;
    tick(1);
    rd = reg_read_data;
    reg_read = 1'b0;
  endtask
  // Slot order is lane order 1A..4B; zero-based branch per lane slot
  function automatic logic [63:0] lmap(input logic sgl, input logic [63:0] b);
    int d[8] = '{0, 2, 1, 3, 4, 6, 5, 7};
    int s[8] = '{0, 5, 1, 4, 7, 2, 6, 3};
    for (int i = 0; i < 8; i++) lmap[8*i+:8] = b[8*(sgl ? s[i] : d[i])+:8];
  endfunction
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #1000000;
    mismatches++;
    test_done();
  end
  initial begin
    {rstn, reg_write, reg_read, reg_address, reg_write_data} = '0;
    {branch_samples, branch_input_positive} = '0;
    void'($urandom(32'h64B76A95));
    tick(20);
    rstn = 1'b1;
    rdr(8'h25);
    check("pattern field", 16'h0007, {13'h0000, rd[6:4]});
    rdr(8'h26);
    check("code a", 16'h0000, {8'h00, rd[15:8]});
    rdr(8'h27);
    check("code b", 16'h0000, {8'h00, rd[15:8]});
    rdr(8'h50);
    check("unmapped", 16'h0000, rd);
    tick(40);
    check("frame length", 16'h0008, frame_len[15:0]);
    check("bit edges", 16'h0004, bit_edges[15:0]);
    for (int m = 0; m < 2; m++) begin
      wr(8'h31, {15'h0000, m[0]});
      for (int k = 0; k < 6; k++) begin
        v = 8'($urandom);
        wr(8'h24, {9'h000, v[2:0], 4'h0});
        branch_input_positive = 8'($urandom);
        branch_samples = (k == 0) ? '0 : (k == 1) ? '1 : {$urandom, $urandom};
        tick(8);
        check("swap", {8'h00, branch_input_positive ^ (m[0] ? {8{v[2]}} : {{4{v[1]}}, {4{v[0]}}})},
              {8'h00, branch_input_swapped});
        check_lanes("lane", lmap(m[0], branch_samples));
      end
    end
    wr(8'h31, 16'h0000);
    wr(8'h34, 16'h003F);
    wr(8'h34, 16'h0140);
    wr(8'h30, 16'h0001);
    branch_samples = {8{8'hC8}};
    tick(8);
    check_lanes("gain", {{5{8'hC8}}, 8'hC6, 8'hC8, 8'hCA});
    wr(8'h30, 16'h0000);
    tick(8);
    check_lanes("gain off", {8{8'hC8}});
    ca = 8'($urandom);
    cb = ca ^ 8'h5A;
    wr(8'h26, {ca, 8'h00});
    wr(8'h27, {cb, 8'h00});
    rdr(8'h26);
    check("code a", {8'h00, ca}, {8'h00, rd[15:8]});
    rdr(8'h27);
    check("code b", {8'h00, cb}, {8'h00, rd[15:8]});
    wr(8'h25, 16'h0040);
    tick(3);
    v = lane_one_a;
    for (int i = 0; i < 260; i++) begin
      tick(1);
      v = v + 8'h01;
      check_lanes("ramp", {8{v}});
    end
    wr(8'h25, 16'h0060);
    tick(3);
    v = lane_one_a + 8'h01;
    tick(1);
    check_lanes("both selected", {8{v}});
    wr(8'h25, 16'h0020);
    tick(3);
    v = lane_one_a;
    for (int i = 0; i < 6; i++) begin
      tick(1);
      v = (v == ca) ? cb : ca;
      check_lanes("toggle", {8{v}});
    end
    wr(8'h25, 16'h0000);
    tick(20);
    check_lanes("single code", {8{ca}});
    check("receiver word", {8'h00, ca}, {8'h00, word});
    wr(8'h25, 16'h0040);
    tick(5);
    rstn = 1'b0;
    tick(3);
    rstn = 1'b1;
    rdr(8'h25);
    check("field after reset", 16'h0007, {13'h0000, rd[6:4]});
    test_done();
  end
endmodule // test_adc_output_pattern_and_lane_map
`default_nettype wire
